// file: rpf_pkg.sv
// constants and types for the reset and power-fail controller
package rpf_pkg;
    // nonvolatile configuration byte
    localparam logic [15:0] RPF_CFG_ADDR      = 16'h20FF;
    localparam int          RPF_CFG_LOCK_BIT  = 7;
    localparam int          RPF_CFG_LVL_LO    = 0;
    localparam int          RPF_CFG_LVL_HI    = 1;
    localparam logic [7:0]  RPF_CFG_RESET     = 8'hFF;
    localparam logic [7:0]  RPF_LOCK_DATA     = 8'h5A;
    // threshold encodings of the two level-select bits
    localparam logic [1:0]  RPF_LVL_2V4       = 2'h0;
    localparam logic [1:0]  RPF_LVL_2V7       = 2'h1;
    localparam logic [1:0]  RPF_LVL_3V0       = 2'h2;
    localparam logic [1:0]  RPF_LVL_DEFAULT   = 2'h3;
    // power-fail control register fields
    localparam int          RPF_PFC_EN_BIT    = 0;
    localparam int          RPF_PFC_MODE_BIT  = 1;
    localparam logic [7:0]  RPF_PFC_RESET     = 8'h00;
    // clock control register fields
    localparam int          RPF_CKC_WDSEL_BIT = 5;
    localparam logic [7:0]  RPF_CKC_RESET     = 8'h00;
    // reset vector
    localparam logic [15:0] RPF_VEC_LO_ADDR   = 16'hFFFE;
    localparam logic [15:0] RPF_VEC_HI_ADDR   = 16'hFFFF;
    // timing
    localparam int          RPF_CLK_HZ        = 50_000_000;
    localparam int          RPF_PIN_MIN_CYC   = 8;
    localparam int          RPF_STAB_US_X10   = 655;
    localparam int          RPF_STAB_REF_MHZ  = 4;
    localparam int          RPF_STAB_EXTRA    = 7;
    // 65.5 ms at 4 MHz is 262000 oscillator periods
    localparam int          RPF_STAB_CYC      =
        RPF_STAB_US_X10 * 100 * RPF_STAB_REF_MHZ;
    localparam int          RPF_PF_NS         = 100;
    localparam int          RPF_PF_CYC        =
        (RPF_PF_NS * (RPF_CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [3:0] {
        RPF_ST_HOLD  = 4'b0001,
        RPF_ST_STAB  = 4'b0010,
        RPF_ST_VEC   = 4'b0100,
        RPF_ST_RUN   = 4'b1000
    } rpf_state_t;
endpackage

// file: rpf_reset_ctrl.sv
// reset sequencing, power-fail supervision and configuration byte
//
// What this block does
// - System reset comes from pin, watchdog, power fail or address fail.
// - Pin held low at least 8 clocks resets and initialises state.
// - After release wait 65.5 ms at 4 MHz plus 7 clocks before execution.
// - On release fetch program counter vector from FFFE and FFFF.
// - No reset source touches data RAM contents.
// - Reset clears page register and flag, main clock, peripherals, watchdog, PFD.
// - Fetch from unimplemented or RAM region raises address-fail reset if enabled.
// - Power-fail detector acts only while its enable flag is set.
// - Supply low for 100 ns resets or freezes per mode bit; the code needs 6 synced low samples, 120 ns at 50 MHz.
// - Threshold is 2.4, 2.7 or 3.0 V from two config bits.
// - Unprogrammed level bits give the 2.7 V threshold.
// - 3.0 V threshold under 3 V operation freezes permanently.
// - Config byte at 20FF only reachable in program/verify mode.
// - Locked flash reads through programming port return 5A.
// - Lock refuses writes and readout of user program area.
// - Watchdog reset-select bit set turns timeout into reset.
`timescale 1ns/10ps
`default_nettype none
module rpf_reset_ctrl
    import rpf_pkg::*;
#(
    parameter int STAB_CYC = RPF_STAB_CYC + RPF_STAB_EXTRA,
    parameter int PIN_CYC  = RPF_PIN_MIN_CYC,
    parameter int PF_CYC   = RPF_PF_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // external pin and supply comparators (asynchronous)
    input  wire logic        reset_n_pin_i,
    input  wire logic        vdd_below_2v4_i,
    input  wire logic        vdd_below_2v7_i,
    input  wire logic        vdd_below_3v0_i,
    // watchdog and fetch monitor
    input  wire logic        wdt_timeout_i,
    input  wire logic        fetch_i,
    input  wire logic [15:0] fetch_addr_i,
    input  wire logic        addr_fail_en_i,
    input  wire logic [15:0] code_lo_addr_i,
    input  wire logic [15:0] ram_hi_addr_i,
    // cpu register writes
    input  wire logic        pfc_wr_i,
    input  wire logic        ckc_wr_i,
    input  wire logic [7:0]  cpu_wdata_i,
    // vector fetch from program memory
    input  wire logic [7:0]  vec_data_i,
    output logic      [15:0] vec_addr_o,
    // flash programming port
    input  wire logic        prog_mode_i,
    input  wire logic        prog_rd_i,
    input  wire logic        prog_wr_i,
    input  wire logic [15:0] prog_addr_i,
    input  wire logic [7:0]  prog_wdata_i,
    input  wire logic [7:0]  flash_rdata_i,
    output logic      [7:0]  prog_rdata_o,
    output logic             flash_wr_o,
    // outputs to core
    output logic             sys_reset_o,
    output logic             core_run_o,
    output logic             freeze_o,
    output logic      [15:0] pc_o,
    output logic             pc_load_o,
    output logic      [7:0]  pfc_o,
    output logic      [7:0]  ckc_o,
    output logic      [7:0]  cfg_o,
    output logic      [3:0]  reset_cause_o
);
    // synchronisers
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
        end else begin
            sync1_reg <= {vdd_below_3v0_i, vdd_below_2v7_i,
                          vdd_below_2v4_i, ~reset_n_pin_i};
            sync2_reg <= sync1_reg;
        end
    end
    logic pin_low;
    assign pin_low = sync2_reg[0];

    // pin low-time filter
    logic [7:0] pin_cnt_reg, pin_cnt_next;
    always_comb begin
        pin_cnt_next = 8'h00;
        if (pin_low && pin_cnt_reg != 8'(PIN_CYC))
            pin_cnt_next = pin_cnt_reg + 8'h01;
        else if (pin_low)
            pin_cnt_next = pin_cnt_reg;
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) pin_cnt_reg <= 8'h00;
        else       pin_cnt_reg <= pin_cnt_next;
    end
    logic src_pin;
    // the eighth synced low sample already counts as a valid pulse
    assign src_pin = pin_low && (pin_cnt_reg >= 8'(PIN_CYC - 1));

    // configuration byte and thresholds
    logic [7:0] cfg_reg, cfg_next;
    logic [1:0] lvl;
    logic       below;
    always_comb begin
        lvl = cfg_reg[RPF_CFG_LVL_HI:RPF_CFG_LVL_LO];
        case (lvl)
            RPF_LVL_2V4: below = sync2_reg[1];
            RPF_LVL_3V0: below = sync2_reg[3];
            default:     below = sync2_reg[2];
        endcase
    end

    // power-fail detector
    logic [7:0] pfc_reg, pfc_next;
    logic [7:0] ckc_reg, ckc_next;
    logic [7:0] pf_cnt_reg, pf_cnt_next;
    logic       pf_en;
    assign pf_en = pfc_reg[RPF_PFC_EN_BIT];
    always_comb begin
        pf_cnt_next = 8'h00;
        if (pf_en && below) begin
            if (pf_cnt_reg != 8'(PF_CYC))
                pf_cnt_next = pf_cnt_reg + 8'h01;
            else
                pf_cnt_next = pf_cnt_reg;
        end
    end
    logic pf_hit;
    // under 3 V with the 3.0 V level the fail persists and freeze stays on
    assign pf_hit = pf_en && below && (pf_cnt_reg == 8'(PF_CYC));
    logic src_pf, freeze_pf;
    assign src_pf    = pf_hit && !pfc_reg[RPF_PFC_MODE_BIT];
    assign freeze_pf = pf_hit && pfc_reg[RPF_PFC_MODE_BIT];

    // watchdog and address fail
    logic src_wdt, src_af;
    assign src_wdt = wdt_timeout_i && ckc_reg[RPF_CKC_WDSEL_BIT];
    assign src_af  = addr_fail_en_i && fetch_i && core_run_o &&
                     (fetch_addr_i < code_lo_addr_i ||
                      fetch_addr_i <= ram_hi_addr_i);

    logic any_src;
    assign any_src = src_pin | src_wdt | src_pf | src_af;

    // sequencer
    rpf_state_t  st_reg, st_next;
    logic [31:0] stab_reg, stab_next;
    logic [15:0] pc_reg, pc_next;
    logic        vbyte_reg, vbyte_next;
    logic [3:0]  cause_reg, cause_next;
    always_comb begin
        st_next    = st_reg;
        stab_next  = stab_reg;
        pc_next    = pc_reg;
        vbyte_next = vbyte_reg;
        cause_next = cause_reg | {src_af, src_pf, src_wdt, src_pin};
        if (any_src) begin
            st_next   = RPF_ST_HOLD;
            stab_next = 32'h0;
        end else begin
            case (st_reg)
                RPF_ST_HOLD: begin
                    st_next   = RPF_ST_STAB;
                    stab_next = 32'h0;
                end
                RPF_ST_STAB: begin
                    if (stab_reg == 32'(STAB_CYC - 1)) begin
                        st_next    = RPF_ST_VEC;
                        vbyte_next = 1'b0;
                    end else begin
                        stab_next = stab_reg + 32'h1;
                    end
                end
                RPF_ST_VEC: begin
                    if (!vbyte_reg) begin
                        pc_next[7:0] = vec_data_i;
                        vbyte_next   = 1'b1;
                    end else begin
                        pc_next[15:8] = vec_data_i;
                        st_next       = RPF_ST_RUN;
                    end
                end
                RPF_ST_RUN: cause_next = cause_reg;
                default:    st_next = RPF_ST_HOLD;
            endcase
        end
    end

    // register writes; reset state clears controls but RAM is not here
    always_comb begin
        pfc_next = pfc_reg;
        ckc_next = ckc_reg;
        cfg_next = cfg_reg;
        if (st_reg != RPF_ST_RUN || any_src) begin
            pfc_next = RPF_PFC_RESET;
            ckc_next = RPF_CKC_RESET;
        end else begin
            if (pfc_wr_i) pfc_next = cpu_wdata_i;
            if (ckc_wr_i) ckc_next = cpu_wdata_i;
        end
        if (prog_mode_i && prog_wr_i && prog_addr_i == RPF_CFG_ADDR)
            cfg_next = prog_wdata_i;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg     <= RPF_ST_HOLD;
            stab_reg   <= 32'h0;
            pc_reg     <= 16'h0000;
            vbyte_reg  <= 1'b0;
            cause_reg  <= 4'h0;
            pf_cnt_reg <= 8'h00;
            pfc_reg    <= RPF_PFC_RESET;
            ckc_reg    <= RPF_CKC_RESET;
            cfg_reg    <= RPF_CFG_RESET;
        end else begin
            st_reg     <= st_next;
            stab_reg   <= stab_next;
            pc_reg     <= pc_next;
            vbyte_reg  <= vbyte_next;
            cause_reg  <= cause_next;
            pf_cnt_reg <= pf_cnt_next;
            pfc_reg    <= pfc_next;
            ckc_reg    <= ckc_next;
            cfg_reg    <= cfg_next;
        end
    end

    // programming port read path; lock bit programmed means 0
    logic locked;
    logic [7:0] prd_next, prd_reg;
    assign locked = !cfg_reg[RPF_CFG_LOCK_BIT];
    always_comb begin
        prd_next = prd_reg;
        if (prog_mode_i && prog_rd_i) begin
            if (prog_addr_i == RPF_CFG_ADDR)
                prd_next = cfg_reg;
            else if (locked)
                prd_next = RPF_LOCK_DATA;
            else
                prd_next = flash_rdata_i;
        end
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) prd_reg <= 8'h00;
        else       prd_reg <= prd_next;
    end

    assign flash_wr_o    = prog_mode_i && prog_wr_i && !locked &&
                           prog_addr_i != RPF_CFG_ADDR;
    assign prog_rdata_o  = prd_reg;
    assign sys_reset_o   = (st_reg != RPF_ST_RUN);
    assign core_run_o    = (st_reg == RPF_ST_RUN) && !freeze_pf;
    assign freeze_o      = freeze_pf;
    assign vec_addr_o    = vbyte_reg ? RPF_VEC_HI_ADDR : RPF_VEC_LO_ADDR;
    assign pc_o          = pc_reg;
    assign pc_load_o     = (st_reg == RPF_ST_VEC) && vbyte_reg && !any_src;
    assign pfc_o         = pfc_reg;
    assign ckc_o         = ckc_reg;
    assign cfg_o         = cfg_reg;
    assign reset_cause_o = cause_reg;
endmodule
`default_nettype wire

// file: rpf_reset_ctrl_properties.sv
// assertions for the reset and power-fail controller
`timescale 1ns/10ps
`default_nettype none
module rpf_reset_ctrl_chk
    import rpf_pkg::*;
#(
    parameter int STAB_CYC = 20
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        reset_n_pin_i,
    input wire logic        vdd_below_2v7_i,
    input wire logic        wdt_timeout_i,
    input wire logic        prog_mode_i,
    input wire logic        prog_rd_i,
    input wire logic [15:0] prog_addr_i,
    input wire logic [7:0]  prog_rdata_o,
    input wire logic        flash_wr_o,
    input wire logic        sys_reset_o,
    input wire logic        freeze_o,
    input wire logic        pc_load_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic [7:0]  pfc_o,
    input wire logic [7:0]  ckc_o,
    input wire logic [7:0]  cfg_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    int   quiet_reg;
    int   quiet_next;
    logic lvl27;
    // cycles since a visible source; internal sources only lengthen the wait
    always_comb begin
        quiet_next = quiet_reg + 1;
        if (!reset_n_pin_i || (wdt_timeout_i && ckc_o[RPF_CKC_WDSEL_BIT]))
            quiet_next = 0;
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i)
            quiet_reg <= 0;
        else
            quiet_reg <= quiet_next;
    end
    assign lvl27 = cfg_o[1:0] == RPF_LVL_2V7 || cfg_o[1:0] == RPF_LVL_DEFAULT;
    a_stab_wait: assert property ($fell(sys_reset_o) |-> quiet_reg >= STAB_CYC)
        else $error("reset released before the stabilisation wait");
    a_pin_reset: assert property ((!reset_n_pin_i)[*8] ##1 (!reset_n_pin_i)[*6]
        |-> sys_reset_o) else $error("long pin pulse gave no reset");
    a_vector_order: assert property (pc_load_o |-> vec_addr_o == RPF_VEC_HI_ADDR
        && $past(vec_addr_o) == RPF_VEC_LO_ADDR) else $error("vector order wrong");
    a_run_after_vec: assert property ($fell(sys_reset_o) |-> $past(pc_load_o))
        else $error("run began without a vector load");
    a_reset_clears: assert property (sys_reset_o[*3] |-> pfc_o == RPF_PFC_RESET
        && ckc_o == RPF_CKC_RESET) else $error("control regs not cleared");
    a_pf_off: assert property (!pfc_o[RPF_PFC_EN_BIT] |-> !freeze_o)
        else $error("freeze with detector disabled");
    a_pf_freeze: assert property ((pfc_o[1:0] == 2'h3 && lvl27 && vdd_below_2v7_i)[*8]
        |=> freeze_o) else $error("low supply gave no freeze");
    a_pf_reset: assert property ((pfc_o[1:0] == 2'h1 && lvl27 && vdd_below_2v7_i)[*8]
        |=> sys_reset_o) else $error("low supply gave no reset");
    a_lock_read: assert property (prog_mode_i && prog_rd_i && !cfg_o[RPF_CFG_LOCK_BIT]
        && prog_addr_i != RPF_CFG_ADDR |=> prog_rdata_o == RPF_LOCK_DATA)
        else $error("locked read leaked data");
    a_lock_write: assert property (!cfg_o[RPF_CFG_LOCK_BIT] |-> !flash_wr_o)
        else $error("locked flash was written");
    cover property ($rose(freeze_o));
    cover property (pc_load_o);
    cover property (prog_rd_i && !cfg_o[RPF_CFG_LOCK_BIT]);
endmodule
bind rpf_reset_ctrl rpf_reset_ctrl_chk #(.STAB_CYC(STAB_CYC)) rpf_reset_ctrl_chk_inst (
    .clk_sys_i, .rst_i, .reset_n_pin_i, .vdd_below_2v7_i, .wdt_timeout_i,
    .prog_mode_i, .prog_rd_i, .prog_addr_i, .prog_rdata_o, .flash_wr_o,
    .sys_reset_o, .freeze_o, .pc_load_o, .vec_addr_o, .pfc_o, .ckc_o, .cfg_o);
`default_nettype wire

// file: rpf_supply_model.sv
// supply comparators and reset pin driver facing the controller
`timescale 1ns/10ps
`default_nettype none
module rpf_supply_model (
    input  wire logic clk_sys_i,
    output var logic  reset_n_pin_o,
    output logic      below_2v4_o,
    output logic      below_2v7_o,
    output logic      below_3v0_o
);
    logic [11:0] volt_mv = 12'hCE4;
    initial reset_n_pin_o = 1'b1;
    assign below_2v4_o = volt_mv <= 12'h960;
    assign below_2v7_o = volt_mv <= 12'hA8C;
    assign below_3v0_o = volt_mv <= 12'hBB8;
    // callers keep n at 8 or more, shorter pulses are not a valid reset
    task automatic press(input int n);
        @(posedge clk_sys_i);
        reset_n_pin_o <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        reset_n_pin_o <= 1'b1;
    endtask
    task automatic set_volt(input logic [11:0] mv);
        @(posedge clk_sys_i);
        volt_mv <= mv;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// testbench for the reset and power-fail controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rpf_pkg::*;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, seen = 1'b0;
    logic        reset_n_pin_i, vdd_below_2v4_i, vdd_below_2v7_i, vdd_below_3v0_i;
    logic        wdt_timeout_i, fetch_i, addr_fail_en_i, pfc_wr_i, ckc_wr_i;
    logic        prog_mode_i, prog_rd_i, prog_wr_i, flash_wr_o, sys_reset_o;
    logic        core_run_o, freeze_o, pc_load_o;
    logic [3:0]  reset_cause_o;
    logic [7:0]  cpu_wdata_i, vec_data_i, prog_wdata_i, flash_rdata_i;
    logic [7:0]  prog_rdata_o, pfc_o, ckc_o, cfg_o, vlo, vhi;
    logic [15:0] fetch_addr_i, code_lo_addr_i, ram_hi_addr_i, vec_addr_o;
    logic [15:0] prog_addr_i, pc_o;
    logic [31:0] seed = 32'h00015CE7;
    int          failures = 0, checks = 0;
    logic [15:0] exp_q[$];
    always #10 clk_sys_i = ~clk_sys_i;
    assign vec_data_i = vec_addr_o[0] ? vhi : vlo;
    rpf_reset_ctrl #(.STAB_CYC(20)) rpf_reset_ctrl_inst (.*);
    rpf_supply_model rpf_supply_model_inst (.clk_sys_i, .reset_n_pin_o(reset_n_pin_i),
        .below_2v4_o(vdd_below_2v4_i), .below_2v7_o(vdd_below_2v7_i),
        .below_3v0_o(vdd_below_3v0_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic hit(input int sel);
        case (sel)
            0: return core_run_o === 1'b1 && sys_reset_o === 1'b0;
            1: return sys_reset_o === 1'b1;
            default: return freeze_o === 1'b1;
        endcase
    endfunction
    task automatic wait_on(input int sel);
        int n;
        for (n = 0; n < 400 && !hit(sel); n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (n == 400) begin
            failures++;
            wrap_up();
        end
    endtask
    // fresh vector bytes in program memory, the pc they should give is noted
    task automatic new_vec();
        seed = lfsr(seed);
        vlo <= seed[7:0];
        vhi <= seed[15:8];
        exp_q.push_back(seed[15:0]);
    endtask
    task automatic cpu_w(input logic ck, input logic [7:0] d);
        @(posedge clk_sys_i);
        pfc_wr_i <= !ck;
        ckc_wr_i <= ck;
        cpu_wdata_i <= d;
        @(posedge clk_sys_i);
        pfc_wr_i <= 1'b0;
        ckc_wr_i <= 1'b0;
    endtask
    task automatic prog(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        prog_rd_i <= !wr;
        prog_wr_i <= wr;
        prog_addr_i <= a;
        prog_wdata_i <= d;
        @(posedge clk_sys_i);
        prog_rd_i <= 1'b0;
        prog_wr_i <= 1'b0;
        #1;
    endtask
    always @(posedge clk_sys_i) begin
        seen <= pc_load_o;
        if (seen === 1'b1)
            chk(pc_o, exp_q.pop_front());
    end
    initial begin
        {wdt_timeout_i, fetch_i, addr_fail_en_i, pfc_wr_i, ckc_wr_i} = 5'h00;
        {prog_mode_i, prog_rd_i, prog_wr_i} = 3'h0;
        {cpu_wdata_i, prog_wdata_i, flash_rdata_i} = 24'h000000;
        {fetch_addr_i, prog_addr_i} = 32'h00000000;
        new_vec();
        code_lo_addr_i <= 16'h2000 | (seed[15:0] & 16'h0FFF);
        ram_hi_addr_i <= 16'h0400 | (seed[31:16] & 16'h03FF);
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wait_on(0);
        chk(cfg_o, RPF_CFG_RESET);
        chk({pfc_o, ckc_o}, 16'h0000);
        $display("test boot done");
        new_vec();
        rpf_supply_model_inst.press(8);
        wait_on(1);
        chk(reset_cause_o[0], 1'b1);
        wait_on(0);
        $display("test pin done");
        rpf_supply_model_inst.set_volt(12'hA28);
        repeat (20) @(posedge clk_sys_i);
        chk({freeze_o, sys_reset_o}, 2'h0);
        cpu_w(1'b0, 8'h03);
        wait_on(2);
        rpf_supply_model_inst.set_volt(12'hCE4);
        repeat (10) @(posedge clk_sys_i);
        chk(freeze_o, 1'b0);
        cpu_w(1'b0, 8'h01);
        new_vec();
        rpf_supply_model_inst.set_volt(12'hA28);
        wait_on(1);
        chk(reset_cause_o[2], 1'b1);
        rpf_supply_model_inst.set_volt(12'hCE4);
        wait_on(0);
        chk(pfc_o, RPF_PFC_RESET);
        $display("test power fail done");
        cpu_w(1'b1, 8'h20);
        new_vec();
        @(posedge clk_sys_i);
        wdt_timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        wdt_timeout_i <= 1'b0;
        wait_on(1);
        chk(reset_cause_o[1], 1'b1);
        wait_on(0);
        chk(ckc_o, RPF_CKC_RESET);
        addr_fail_en_i <= 1'b1;
        new_vec();
        @(posedge clk_sys_i);
        fetch_i <= 1'b1;
        fetch_addr_i <= seed[31:16] & 16'h03FF;
        @(posedge clk_sys_i);
        fetch_i <= 1'b0;
        wait_on(1);
        chk(reset_cause_o[3], 1'b1);
        wait_on(0);
        $display("test watchdog and fetch done");
        seed = lfsr(seed);
        prog_mode_i <= 1'b1;
        flash_rdata_i <= seed[7:0];
        prog(1'b0, 16'h1000, 8'h00);
        chk(prog_rdata_o, seed[7:0]);
        prog(1'b1, RPF_CFG_ADDR, 8'h7E);
        chk(cfg_o, 8'h7E);
        prog(1'b0, 16'h1000, 8'h00);
        chk(prog_rdata_o, RPF_LOCK_DATA);
        prog(1'b1, 16'h1000, 8'h11);
        prog_mode_i <= 1'b0;
        cpu_w(1'b0, 8'h03);
        rpf_supply_model_inst.set_volt(12'hB54);
        wait_on(2);
        $display("test config done");
        chk(16'(exp_q.size()), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
